//--- bench/ppc_regs_bench.sv
/*
  Self-checking bench of the port PHY register bank.
  Assumes ppc_regs answers APB and that the checker is bound to it.
*/
`timescale 1ns/10ps
`default_nettype none

module ppc_regs_bench;
  import ppc_pkg::*;
  typedef struct packed {
    logic w; logic [11:0] a; logic [15:0] d; logic [3:0] s; logic [15:0] x; logic e;
  } ppc_row_s;
  logic        clock = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic [3:0]  pstrb = 4'h0, act = 4'h5, led;
  logic        pready, pslverr, e;
  logic [11:0] phy = 12'hDB5;
  logic [7:0]  ctl;
  logic [4:0]  adv;
  int          fails = 0, checked = 0;
  // Writes carry 16'h0 expected data because a write returns zero read data.
  ppc_row_s rows [22] = '{
    '{0, 12'h3D8, 0, 0, 16'h00FF, 0}, '{0, 12'h3E0, 0, 0, 16'hA4F5, 0},
    '{1, 12'h3D8, 16'hFFFF, 3, 0, 0}, '{0, 12'h3D8, 0, 0, 16'hC6FF, 0},
    '{0, 12'h390, 0, 0, 16'h313B, 0}, '{0, 12'h3B0, 0, 0, 16'h05E1, 0},
    '{1, 12'h390, 0, 3, 0, 0},        '{0, 12'h3E0, 0, 0, 16'h24F5, 0},
    '{1, 12'h3B0, 16'h0540, 3, 0, 0}, '{0, 12'h3D8, 0, 0, 16'h001A, 0},
    '{0, 12'h3B8, 0, 0, 16'h04A1, 0}, '{0, 12'h398, 0, 0, 16'h0024, 0},
    '{1, 12'h3E0, 16'h7FFF, 3, 0, 0}, '{0, 12'h3E0, 0, 0, 16'h24F5, 0},
    '{1, 12'h3D8, 16'h80FF, 2, 0, 0}, '{0, 12'h3D8, 0, 0, 16'h801A, 0},
    '{1, 12'h3E8, 16'hFFFF, 3, 0, 0}, '{0, 12'h3E8, 0, 0, 0, 0},
    '{0, 12'h3FC, 0, 0, 0, 0},        '{0, 12'h004, 0, 0, 0, 1},
    '{1, 12'h3DA, 0, 3, 0, 1},        '{0, 12'h3D8, 0, 0, 16'h801A, 0}};

  ppc_regs uut (.clock, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
    .pready, .pslverr, .phy_polarity_reversed(phy[11]), .phy_speed_100(phy[10]),
    .phy_full_duplex(phy[9]), .phy_mdi(phy[8]), .phy_an_done(phy[7]),
    .phy_an_failed(phy[6]), .phy_link_good(phy[5]), .lp_pause(phy[4]),
    .lp_100_full(phy[3]), .lp_100_half(phy[2]), .lp_10_full(phy[1]), .lp_10_half(phy[0]),
    .led_act_3(act[3]), .led_act_2(act[2]), .led_act_1(act[1]), .led_act_0(act[0]),
    .port_led_3(led[3]), .port_led_2(led[2]), .port_led_1(led[1]), .port_led_0(led[0]),
    .tx_disable(ctl[7]), .an_restart(ctl[6]), .an_enable(ctl[5]),
    .auto_mdix_disable(ctl[4]), .force_mdix(ctl[3]), .force_speed_100(ctl[2]),
    .duplex_full(ctl[1]), .crossover_algorithm_select(ctl[0]), .adv_pause(adv[4]),
    .adv_100_full(adv[3]), .adv_100_half(adv[2]), .adv_10_full(adv[1]),
    .adv_10_half(adv[0]));

  always #2.5 clock = ~clock;

  // ----------------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------------
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [15:0] d,
                     input logic [3:0] s, output logic [31:0] rd, output logic er);
    @(posedge clock);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= {16'h0000, d};
    pstrb  <= s;
    @(posedge clock);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never sees pready.
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    apb(1'b1, a, d, 4'h3, r, e);
  endtask

  // ----------------------------------------------------------------
  // Sequence of tests
  // ----------------------------------------------------------------
  initial begin
    #20000;
    fails++;
    stop_test;
  end

  initial begin
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d, rows[i].s, r, e);
      chk(r, {16'h0000, rows[i].x});
      chk(e, rows[i].e);
    end
    $display("register rows done");
    chk(led, 4'hF);
    chk(adv, 5'h1A);
    phy[9] <= 1'b1;
    wr(12'h3D8, 16'h4000);
    repeat (3) @(posedge clock);
    chk(led, act);
    chk(ctl[7], 1'b1);
    chk(ctl[5:1], 5'h00);
    phy[9] <= 1'b0;
    wr(12'h3D8, 16'h00E0);
    repeat (4) @(posedge clock);
    chk(ctl[5:1], 5'h12);
    phy[6] <= 1'b1;
    repeat (4) @(posedge clock);
    chk(ctl[1], 1'b1);
    phy[6] <= 1'b0;
    $display("control outputs done");
    wr(12'h3D8, 16'h0200);
    repeat (3) @(posedge clock);
    chk(ctl[4:3], 2'b00);
    wr(12'h3D8, 16'h0600);
    repeat (3) @(posedge clock);
    chk(ctl[4:3], 2'b11);
    $display("crossover done");
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    apb(1'b0, 12'h3D8, 16'h0000, 4'h0, r, e);
    chk(r, 32'h000000FF);
    chk(ctl[0], 1'b1);
    $display("second reset done");
    stop_test;
  end
endmodule

`default_nettype wire

//--- bench/ppc_regs_sva.sv
/*
  Concurrent checks on the ports of the port PHY register bank.
  Assumes a zero wait state APB slave and two flop input synchronisers.
*/
`timescale 1ns/10ps
`default_nettype none

module ppc_regs_sva (
  // Clock, reset and APB
  input wire logic                       clock, rst, psel, penable, pwrite,
  input wire logic [ppc_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0]                pwdata, prdata,
  input wire logic [3:0]                 pstrb,
  input wire logic                       pslverr,
  // PHY levels and control outputs
  input wire logic phy_polarity_reversed, phy_speed_100, phy_full_duplex,
  input wire logic phy_an_failed, phy_link_good, tx_disable, an_restart,
  input wire logic an_enable, auto_mdix_disable, force_mdix, force_speed_100,
  input wire logic duplex_full, crossover_algorithm_select,
  input wire logic port_led_3, port_led_2, port_led_1, port_led_0,
  input wire logic adv_pause, adv_100_full, adv_100_half, adv_10_full, adv_10_half
);
  import ppc_pkg::*;
  // ----------------------------------------------------------------
  // Decodes and sequences
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  logic acc, wr_c, wr_s;
  assign acc  = psel && penable;
  assign wr_c = acc && pwrite && paddr == {IDX_CTRL, 2'b00};
  assign wr_s = acc && pwrite && paddr == {IDX_STAT, 2'b00};
  sequence s_hi; wr_c && pstrb[1]; endsequence
  sequence s_lo; wr_c && pstrb[0]; endsequence
  // Status levels are only trusted once they have outlived the synchroniser.
  sequence s_quiet;
    $stable({phy_speed_100, phy_full_duplex, phy_polarity_reversed, phy_link_good})[*4];
  endsequence
  sequence s_rd_stat; psel && !penable && !pwrite && paddr == {IDX_STAT, 2'b00}; endsequence

  AST_LED_OFF: assert property (s_hi ##0 pwdata[15] |-> ##2
    (port_led_3 && port_led_2 && port_led_1 && port_led_0)) else $error("leds not blanked");
  AST_TX_DIS: assert property (s_hi |=> tx_disable == $past(pwdata[14]))
    else $error("tx disable wrong");
  AST_RESTART: assert property (s_hi ##0 pwdata[13] |=> an_restart ##1 !an_restart)
    else $error("restart not one pulse");
  AST_MDIX_OFF: assert property (s_hi |=> auto_mdix_disable == $past(pwdata[10]))
    else $error("auto crossover control wrong");
  AST_NO_FORCE: assert property (!auto_mdix_disable [*2] |-> !force_mdix)
    else $error("crossover forced while automatic");
  AST_AN_SPEED: assert property (s_lo |=> an_enable == $past(pwdata[7])
    && force_speed_100 == $past(pwdata[6])) else $error("negotiation or speed wrong");
  AST_ADV: assert property (s_lo |=> {adv_pause, adv_100_full, adv_100_half,
    adv_10_full, adv_10_half} == $past(pwdata[4:0])) else $error("advertisement wrong");
  AST_DUPLEX: assert property ((an_enable && !phy_an_failed
    && $stable(phy_full_duplex)) [*4] |-> duplex_full == phy_full_duplex)
    else $error("negotiated duplex not followed");
  AST_XALG: assert property (wr_s && pstrb[1] |=>
    crossover_algorithm_select == $past(pwdata[15])) else $error("algorithm select wrong");
  AST_STAT: assert property (s_quiet ##0 s_rd_stat |=>
    prdata[13] == $past(phy_polarity_reversed) && prdata[10] == $past(phy_speed_100)
    && prdata[9] == $past(phy_full_duplex) && prdata[5] == $past(phy_link_good)
    && (prdata & 32'hFFFF5900) == 32'h0) else $error("status read wrong");
  AST_RSV: assert property (acc && paddr[1:0] == 2'b00 && paddr >= {IDX_RSV_LO, 2'b00}
    && paddr <= {IDX_RSV_HI, 2'b00} |-> !pslverr && prdata == 32'h0)
    else $error("reserved access wrong");
  AST_MISALIGN: assert property (acc && paddr[1:0] != 2'b00 |-> pslverr)
    else $error("misaligned access accepted");
endmodule

bind ppc_regs ppc_regs_sva chk (.clock, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pstrb, .pslverr, .phy_polarity_reversed, .phy_speed_100, .phy_full_duplex,
  .phy_an_failed, .phy_link_good, .tx_disable, .an_restart, .an_enable,
  .auto_mdix_disable, .force_mdix, .force_speed_100, .duplex_full,
  .crossover_algorithm_select, .port_led_3, .port_led_2, .port_led_1, .port_led_0,
  .adv_pause, .adv_100_full, .adv_100_half, .adv_10_full, .adv_10_half);

`default_nettype wire

//--- hw/ppc_pkg.sv
/*
  Constants for the port PHY control and status register bank: register
  indices, byte address scaling, field positions, masks and reset values.
  Assumes a 32-bit APB slave with one aligned word per register.
*/
`default_nettype none

package ppc_pkg;

  // ----------------------------------------------------------------------
  // Register indices and addressing
  // ----------------------------------------------------------------------
  localparam int          ADDR_W        = 12;
  localparam int          IDX_W         = 10;
  localparam int          IDX_LSB       = 2;
  localparam logic [IDX_W-1:0] IDX_BCTL = 10'h0E4;
  localparam logic [IDX_W-1:0] IDX_BSTA = 10'h0E6;
  localparam logic [IDX_W-1:0] IDX_ADV  = 10'h0EC;
  localparam logic [IDX_W-1:0] IDX_LPA  = 10'h0EE;
  localparam logic [IDX_W-1:0] IDX_CTRL = 10'h0F6;
  localparam logic [IDX_W-1:0] IDX_STAT = 10'h0F8;
  localparam logic [IDX_W-1:0] IDX_RSV_LO = 10'h0FA;
  localparam logic [IDX_W-1:0] IDX_RSV_HI = 10'h0FF;

  // ----------------------------------------------------------------------
  // Port PHY control fields
  // ----------------------------------------------------------------------
  localparam int CT_LED_OFF   = 15;
  localparam int CT_TX_DIS    = 14;
  localparam int CT_RESTART   = 13;
  localparam int CT_MDIX_DIS  = 10;
  localparam int CT_FORCE_MDIX = 9;
  localparam int CT_AN_EN     = 7;
  localparam int CT_SPEED     = 6;
  localparam int CT_DUPLEX    = 5;
  localparam int CT_ADV_HI    = 4;
  localparam logic [15:0] CTRL_MASK  = 16'hE6FF;
  localparam logic [15:0] CTRL_RESET = 16'h00FF;

  // ----------------------------------------------------------------------
  // Port PHY status fields
  // ----------------------------------------------------------------------
  localparam int ST_XALG      = 15;
  localparam int ST_POLARITY  = 13;
  localparam int ST_SPEED     = 10;
  localparam int ST_DUPLEX    = 9;
  localparam int ST_MDI       = 7;
  localparam int ST_AN_DONE   = 6;
  localparam int ST_LINK      = 5;
  localparam logic XALG_RESET = 1'b1;

  // ----------------------------------------------------------------------
  // Alias register fields
  // ----------------------------------------------------------------------
  localparam int BC_LED_OFF   = 0;
  localparam int BC_TX_DIS    = 1;
  localparam int BC_MDIX_DIS  = 3;
  localparam int BC_FORCE_MDIX = 4;
  localparam int BC_XALG      = 5;
  localparam int BC_DUPLEX    = 8;
  localparam int BC_RESTART   = 9;
  localparam int BC_AN_EN     = 12;
  localparam int BC_SPEED     = 13;
  localparam int BS_LINK      = 2;
  localparam int BS_AN_DONE   = 5;
  localparam int AB_PAUSE     = 10;
  localparam int AB_HI        = 8;
  localparam int AB_LO        = 5;
  localparam logic [4:0] AB_SELECTOR = 5'h01;

  // ----------------------------------------------------------------------
  // Synchronised PHY inputs
  // ----------------------------------------------------------------------
  localparam int          PHY_IN_W   = 12;
  localparam logic [11:0] PHY_IN_RST = 12'h100;

endpackage

`default_nettype wire

//--- hw/ppc_regs.sv
/*
  Port PHY control and status register bank with an APB slave, alias views
  of the PHY basic control, basic status, advertisement and partner ability
  registers, and the control levels that steer the PHY and the port LEDs.
  Assumes PHY status levels arrive from another domain and LED activity
  levels come from logic on the same clock.

  // Function
  // (R1) Control bit 15 drives all LEDs high
  // (R2) Control bit 14 disables the transmitter
  // (R3) Writing one to bit 13 restarts negotiation
  // (R4) Control bit 10 turns off auto crossover
  // (R5) Bit 9 forces crossover only when auto off
  // (R6) Bit 7 resets one; zero uses bits 6,5
  // (R7) Bit 6 forces 100 or 10 megabit
  // (R8) Bit 5 forced duplex; also when negotiation fails
  // (R9) Bits 4 to 0 advertise, reset one
  // (R10) Control bits alias basic control and advertisement
  // (R11) Status bit 15 writable crossover algorithm, reset one
  // (R12) Status bit 13 shows reversed polarity
  // (R13) Status bit 10 shows 100 megabit speed
  // (R14) Status bit 9 shows full duplex
  // (R15) Status bits 6,5 negotiation done, link good
  // (R16) Status bits 4 to 0 mirror partner ability
  // (R17) Offsets 0xFA to 0xFF reserved, read zero
  // (R18) Reserved bits read zero, writes ignored
*/
// Decided for this implementation: register access over APB.
`timescale 1ns/10ps
`default_nettype none

module ppc_regs (
  // Clock and reset
  input  wire logic                       clock,
  input  wire logic                       rst,
  // APB slave
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [ppc_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                pwdata,
  input  wire logic [3:0]                 pstrb,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  // PHY status levels
  input  wire logic                       phy_polarity_reversed,
  input  wire logic                       phy_speed_100,
  input  wire logic                       phy_full_duplex,
  input  wire logic                       phy_mdi,
  input  wire logic                       phy_an_done,
  input  wire logic                       phy_an_failed,
  input  wire logic                       phy_link_good,
  input  wire logic                       lp_pause,
  input  wire logic                       lp_100_full,
  input  wire logic                       lp_100_half,
  input  wire logic                       lp_10_full,
  input  wire logic                       lp_10_half,
  // LED activity from port logic
  input  wire logic                       led_act_3,
  input  wire logic                       led_act_2,
  input  wire logic                       led_act_1,
  input  wire logic                       led_act_0,
  // LED pins
  output logic                            port_led_3,
  output logic                            port_led_2,
  output logic                            port_led_1,
  output logic                            port_led_0,
  // PHY control levels
  output logic                            tx_disable,
  output logic                            an_restart,
  output logic                            an_enable,
  output logic                            auto_mdix_disable,
  output logic                            force_mdix,
  output logic                            force_speed_100,
  output logic                            duplex_full,
  output logic                            crossover_algorithm_select,
  // Advertised abilities
  output logic                            adv_pause,
  output logic                            adv_100_full,
  output logic                            adv_100_half,
  output logic                            adv_10_full,
  output logic                            adv_10_half
);

  import ppc_pkg::*;

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  logic [15:0]         ctrl_reg;
  logic [15:0]         ctrl_next;
  logic                xalg_reg;
  logic                xalg_next;
  logic [31:0]         rdata_reg;
  logic [31:0]         rdata_next;
  logic                err_reg;
  logic                err_next;
  logic [3:0]          led_reg;
  logic                force_mdix_reg;
  logic                duplex_reg;
  logic [PHY_IN_W-1:0] phy_raw;
  logic [PHY_IN_W-1:0] phy_sync;
  logic [IDX_W-1:0]    idx;
  logic                aligned;
  logic                setup_phase;
  logic                wr_en;
  logic                hit_ctrl;
  logic                hit_stat;
  logic                hit_bctl;
  logic                hit_bsta;
  logic                hit_adv;
  logic                hit_lpa;
  logic                hit_rsv;
  logic                mapped;
  logic [15:0]         ctrl_view;
  logic [15:0]         stat_view;
  logic [15:0]         bctl_view;
  logic [15:0]         bsta_view;
  logic [15:0]         adv_view;
  logic [15:0]         lpa_view;
  logic [4:0]          lp_bits;
  logic                s_polarity;
  logic                s_speed;
  logic                s_duplex;
  logic                s_mdi;
  logic                s_an_done;
  logic                s_an_failed;
  logic                s_link;

  // ----------------------------------------------------------------------
  // Byte-lane merge of a 16-bit register image
  // ----------------------------------------------------------------------
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  strb);
    logic [15:0] res;
    res = old;
    if (strb[0]) begin
      res[7:0] = wd[7:0];
    end
    if (strb[1]) begin
      res[15:8] = wd[15:8];
    end
    return res;
  endfunction

  // ----------------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------------
  assign phy_raw = {phy_polarity_reversed, phy_speed_100, phy_full_duplex,
                    phy_mdi, phy_an_done, phy_an_failed, phy_link_good,
                    lp_pause, lp_100_full, lp_100_half, lp_10_full, lp_10_half};

  ppc_sync #(
    .WIDTH   (PHY_IN_W),
    .RST_VAL (PHY_IN_RST)
  ) u_sync (
    .clock (clock),
    .rst   (rst),
    .din   (phy_raw),
    .dout  (phy_sync)
  );

  assign {s_polarity, s_speed, s_duplex, s_mdi, s_an_done, s_an_failed,
          s_link, lp_bits} = phy_sync;

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  assign idx         = paddr[ADDR_W-1:IDX_LSB];
  assign aligned     = (paddr[IDX_LSB-1:0] == 2'h0);
  assign setup_phase = psel & ~penable;
  assign wr_en       = psel & penable & pwrite & ~err_reg;
  assign hit_ctrl    = aligned & (idx == IDX_CTRL);
  assign hit_stat    = aligned & (idx == IDX_STAT);
  assign hit_bctl    = aligned & (idx == IDX_BCTL);
  assign hit_bsta    = aligned & (idx == IDX_BSTA);
  assign hit_adv     = aligned & (idx == IDX_ADV);
  assign hit_lpa     = aligned & (idx == IDX_LPA);
  assign hit_rsv     = aligned & (idx >= IDX_RSV_LO) & (idx <= IDX_RSV_HI); // (R17)
  assign mapped      = hit_ctrl | hit_stat | hit_bctl | hit_bsta | hit_adv
                     | hit_lpa | hit_rsv;

  // ----------------------------------------------------------------------
  // Register views
  // ----------------------------------------------------------------------
  assign ctrl_view = ctrl_reg & CTRL_MASK; // (R18)

  always_comb begin
    stat_view              = 16'h0000;
    stat_view[ST_XALG]     = xalg_reg;      // (R11)
    stat_view[ST_POLARITY] = s_polarity;    // (R12)
    stat_view[ST_SPEED]    = s_speed;       // (R13)
    stat_view[ST_DUPLEX]   = s_duplex;      // (R14)
    stat_view[ST_MDI]      = s_mdi;
    stat_view[ST_AN_DONE]  = s_an_done;     // (R15)
    stat_view[ST_LINK]     = s_link;        // (R15)
    stat_view[CT_ADV_HI:0] = lp_bits;       // (R16)
  end

  always_comb begin
    bctl_view                = 16'h0000;
    bctl_view[BC_LED_OFF]    = ctrl_reg[CT_LED_OFF];    // (R10)
    bctl_view[BC_TX_DIS]     = ctrl_reg[CT_TX_DIS];
    bctl_view[BC_MDIX_DIS]   = ctrl_reg[CT_MDIX_DIS];
    bctl_view[BC_FORCE_MDIX] = ctrl_reg[CT_FORCE_MDIX];
    bctl_view[BC_XALG]       = xalg_reg;
    bctl_view[BC_DUPLEX]     = ctrl_reg[CT_DUPLEX];
    bctl_view[BC_RESTART]    = ctrl_reg[CT_RESTART];
    bctl_view[BC_AN_EN]      = ctrl_reg[CT_AN_EN];
    bctl_view[BC_SPEED]      = ctrl_reg[CT_SPEED];
  end

  always_comb begin
    bsta_view             = 16'h0000;
    bsta_view[BS_LINK]    = s_link;         // (R15)
    bsta_view[BS_AN_DONE] = s_an_done;
  end

  always_comb begin
    adv_view              = 16'h0000;
    adv_view[AB_PAUSE]    = ctrl_reg[CT_ADV_HI];         // (R10)
    adv_view[AB_HI:AB_LO] = ctrl_reg[CT_ADV_HI-1:0];
    adv_view[CT_ADV_HI:0] = AB_SELECTOR;
  end

  always_comb begin
    lpa_view              = 16'h0000;
    lpa_view[AB_PAUSE]    = lp_bits[CT_ADV_HI];          // (R16)
    lpa_view[AB_HI:AB_LO] = lp_bits[CT_ADV_HI-1:0];
    lpa_view[CT_ADV_HI:0] = AB_SELECTOR;
  end

  // ----------------------------------------------------------------------
  // Write path: one shared store behind the basic control and advertisement aliases
  // ----------------------------------------------------------------------
  always_comb begin
    logic [15:0] w;
    w         = 16'h0000;
    ctrl_next = ctrl_reg;
    xalg_next = xalg_reg;
    ctrl_next[CT_RESTART] = 1'b0; // (R3)
    if (wr_en) begin
      if (hit_ctrl) begin
        ctrl_next = merge16(ctrl_view, pwdata, pstrb) & CTRL_MASK; // (R18)
      end else if (hit_stat) begin
        w         = merge16(stat_view, pwdata, pstrb);
        xalg_next = w[ST_XALG]; // (R11)
      end else if (hit_bctl) begin
        w = merge16(bctl_view, pwdata, pstrb);
        ctrl_next[CT_LED_OFF]    = w[BC_LED_OFF];    // (R10)
        ctrl_next[CT_TX_DIS]     = w[BC_TX_DIS];
        ctrl_next[CT_RESTART]    = w[BC_RESTART];
        ctrl_next[CT_MDIX_DIS]   = w[BC_MDIX_DIS];
        ctrl_next[CT_FORCE_MDIX] = w[BC_FORCE_MDIX];
        ctrl_next[CT_AN_EN]      = w[BC_AN_EN];
        ctrl_next[CT_SPEED]      = w[BC_SPEED];
        ctrl_next[CT_DUPLEX]     = w[BC_DUPLEX];
        xalg_next                = w[BC_XALG];
      end else if (hit_adv) begin
        w = merge16(adv_view, pwdata, pstrb);
        ctrl_next[CT_ADV_HI]     = w[AB_PAUSE];      // (R10)
        ctrl_next[CT_ADV_HI-1:0] = w[AB_HI:AB_LO];
      end
    end
  end

  // Restart is a one-cycle pulse; the stored bit clears itself afterwards.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ctrl_reg <= CTRL_RESET; // (R6) (R9)
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      xalg_reg <= XALG_RESET; // (R11)
    end else begin
      xalg_reg <= xalg_next;
    end
  end

  // ----------------------------------------------------------------------
  // Read path and error answer, captured in the setup cycle
  // ----------------------------------------------------------------------
  always_comb begin
    rdata_next = 32'h0000_0000;
    err_next   = ~mapped;
    if (hit_ctrl) begin
      rdata_next[15:0] = ctrl_view;
    end else if (hit_stat) begin
      rdata_next[15:0] = stat_view;
    end else if (hit_bctl) begin
      rdata_next[15:0] = bctl_view;
    end else if (hit_bsta) begin
      rdata_next[15:0] = bsta_view;
    end else if (hit_adv) begin
      rdata_next[15:0] = adv_view;
    end else if (hit_lpa) begin
      rdata_next[15:0] = lpa_view;
    end
  end

  // Capturing in setup gives registered data with no wait state.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rdata_reg <= 32'h0000_0000;
      err_reg   <= 1'b0;
    end else if (setup_phase) begin
      rdata_reg <= pwrite ? 32'h0000_0000 : rdata_next;
      err_reg   <= err_next;
    end
  end

  assign prdata  = rdata_reg;
  assign pready  = psel & penable;
  assign pslverr = psel & penable & err_reg;

  // ----------------------------------------------------------------------
  // LED pins
  // ----------------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      led_reg <= 4'h0;
    end else if (ctrl_reg[CT_LED_OFF]) begin
      led_reg <= 4'hF; // (R1)
    end else begin
      led_reg <= {led_act_3, led_act_2, led_act_1, led_act_0};
    end
  end

  assign port_led_3 = led_reg[3];
  assign port_led_2 = led_reg[2];
  assign port_led_1 = led_reg[1];
  assign port_led_0 = led_reg[0];

  // ----------------------------------------------------------------------
  // PHY control levels
  // ----------------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      force_mdix_reg <= 1'b0;
    end else begin
      force_mdix_reg <= ctrl_reg[CT_MDIX_DIS] & ctrl_reg[CT_FORCE_MDIX]; // (R5)
    end
  end

  // Forced duplex wins when negotiation is off or failed to resolve.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      duplex_reg <= 1'b0;
    end else if (~ctrl_reg[CT_AN_EN] | s_an_failed) begin
      duplex_reg <= ctrl_reg[CT_DUPLEX]; // (R8)
    end else begin
      duplex_reg <= s_duplex;
    end
  end

  assign tx_disable                 = ctrl_reg[CT_TX_DIS];     // (R2)
  assign an_restart                 = ctrl_reg[CT_RESTART];    // (R3)
  assign an_enable                  = ctrl_reg[CT_AN_EN];      // (R6)
  assign auto_mdix_disable          = ctrl_reg[CT_MDIX_DIS];   // (R4)
  assign force_mdix                 = force_mdix_reg;
  assign force_speed_100            = ctrl_reg[CT_SPEED];      // (R7)
  assign duplex_full                = duplex_reg;
  assign crossover_algorithm_select = xalg_reg;
  assign adv_pause                  = ctrl_reg[CT_ADV_HI];     // (R9)
  assign adv_100_full               = ctrl_reg[CT_ADV_HI-1];
  assign adv_100_half               = ctrl_reg[CT_ADV_HI-2];
  assign adv_10_full                = ctrl_reg[CT_ADV_HI-3];
  assign adv_10_half                = ctrl_reg[CT_ADV_HI-4];

endmodule

`default_nettype wire

//--- hw/ppc_sync.sv
/*
  Two flip-flop synchroniser for a group of independent level inputs.
  Assumes each bit is a slow level; bits are not coherent with each other.
*/
`timescale 1ns/10ps
`default_nettype none

module ppc_sync #(
  parameter int         WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             rst,
  // Levels
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      meta_reg <= RST_VAL;
      sync_reg <= RST_VAL;
    end else begin
      meta_reg <= din;
      sync_reg <= meta_reg;
    end
  end

  assign dout = sync_reg;

endmodule

`default_nettype wire
